// [mtia_top.v]
`include "mtia_regs.vh"

// Function
// - every source individually maskable, any drives pin
// - pin buffer type and polarity programmable
// - de-assert timer, zero field disables it
// - interval starts whenever pin goes inactive
// - timer, software, ready bits held at top
// - summary bits mirror sub-module sources
// - each phy sets its own summary bit
// - phy offers nine separately flagged events
// - phy event needs mask, enable, pin enable
// - power summary shows enabled power event
// - power event needs enable and pin enable
// - timer flag set on count wrap
// - timer flag write one clears
// - timer event needs run, enable, pin enable
// - fieldbus summary from request and mask
// - fieldbus event needs mask, enable, pin enable
// - software flag set on enable rising
// - software event needs enable and pin enable
// - interval in 10 us units, zero releases
// - pin enable clear keeps pin inactive
// - interval clear restarts de-assert counter
// - master bit shows internal line
module mtia_top #(
  parameter PHY_EVENTS   = 9,
  parameter POWER_EVENTS = 5,
  parameter FB_EVENTS    = 32
) (
  input  wire                       sys_clk,
  input  wire                       reset,
  input  wire                       clk_en,
  input  wire [`MTIA_ADDR_W-1:0]    s_axi_awaddr,
  input  wire [2:0]                 s_axi_awprot,
  input  wire                       s_axi_awvalid,
  output wire                       s_axi_awready,
  input  wire [31:0]                s_axi_wdata,
  input  wire [3:0]                 s_axi_wstrb,
  input  wire                       s_axi_wvalid,
  output wire                       s_axi_wready,
  output wire [1:0]                 s_axi_bresp,
  output wire                       s_axi_bvalid,
  input  wire                       s_axi_bready,
  input  wire [`MTIA_ADDR_W-1:0]    s_axi_araddr,
  input  wire [2:0]                 s_axi_arprot,
  input  wire                       s_axi_arvalid,
  output wire                       s_axi_arready,
  output wire [31:0]                s_axi_rdata,
  output wire [1:0]                 s_axi_rresp,
  output wire                       s_axi_rvalid,
  input  wire                       s_axi_rready,
  input  wire [PHY_EVENTS-1:0]      phy_first_source_flags,
  input  wire [PHY_EVENTS-1:0]      phy_first_event_mask,
  input  wire [PHY_EVENTS-1:0]      phy_second_source_flags,
  input  wire [PHY_EVENTS-1:0]      phy_second_event_mask,
  input  wire [POWER_EVENTS-1:0]    power_event_flags,
  input  wire [POWER_EVENTS-1:0]    power_event_enables,
  input  wire [FB_EVENTS-1:0]       fieldbus_event_request,
  input  wire [FB_EVENTS-1:0]       fieldbus_event_mask,
  input  wire                       timer_wrap_pulse,
  input  wire                       timer_run_enable,
  input  wire                       device_ready,
  output wire                       irq_out,
  output wire                       irq_oe_n
);

  // ----------------------------------------
  // timing constants
  // ----------------------------------------
  localparam integer UNIT_CYC_I =
    (`MTIA_DEAS_UNIT_NS + `MTIA_CLK_NS - 1) / `MTIA_CLK_NS;
  localparam [15:0] UNIT_CYC = UNIT_CYC_I[15:0];
  localparam [15:0] PRE_ONE  = 16'h0001;
  localparam [7:0]  UNIT_ONE = 8'h01;

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg                       aw_full_q;
  reg [`MTIA_ADDR_W-1:0]    aw_addr_q;
  reg                       w_full_q;
  reg [31:0]                w_data_q;
  reg [3:0]                 w_strb_q;
  reg                       b_valid_q;
  reg [1:0]                 b_resp_q;
  reg                       r_valid_q;
  reg [31:0]                r_data_q;
  reg [1:0]                 r_resp_q;
  reg [7:0]                 deas_field_q;
  reg                       pin_en_q;
  reg                       pol_high_q;
  reg                       push_pull_q;
  reg                       timer_flag_q;
  reg                       sw_flag_q;
  reg                       ready_flag_q;
  reg                       ready_seen_q;
  reg                       en_phy_a_q;
  reg                       en_phy_b_q;
  reg                       en_power_q;
  reg                       en_timer_q;
  reg                       en_fb_q;
  reg                       en_sw_q;
  reg                       en_ready_q;
  reg                       pin_active_q;
  reg                       deas_busy_q;
  reg [15:0]                pre_cnt_q;
  reg [7:0]                 unit_cnt_q;
  reg                       irq_out_q;
  reg                       irq_oe_n_q;

  // ----------------------------------------
  // source summaries and internal line
  // ----------------------------------------
  wire sum_phy_a = |(phy_first_source_flags & phy_first_event_mask);
  wire sum_phy_b = |(phy_second_source_flags & phy_second_event_mask);
  wire sum_power = |(power_event_flags & power_event_enables);
  wire sum_fb    = |(fieldbus_event_request & fieldbus_event_mask);

  // ----------------------------------------
  // register read words
  // ----------------------------------------
  reg [31:0] status_word;
  always @* begin
    status_word                     = `MTIA_RST_WORD;
    status_word[`MTIA_BIT_PHY_A]    = sum_phy_a;
    status_word[`MTIA_BIT_PHY_B]    = sum_phy_b;
    status_word[`MTIA_BIT_POWER]    = sum_power;
    status_word[`MTIA_BIT_FIELDBUS] = sum_fb;
    status_word[`MTIA_BIT_TIMER]    = timer_flag_q;
    status_word[`MTIA_BIT_SW]       = sw_flag_q;
    status_word[`MTIA_BIT_READY]    = ready_flag_q;
  end

  reg [31:0] enable_word;
  always @* begin
    enable_word                     = `MTIA_RST_WORD;
    enable_word[`MTIA_BIT_PHY_A]    = en_phy_a_q;
    enable_word[`MTIA_BIT_PHY_B]    = en_phy_b_q;
    enable_word[`MTIA_BIT_POWER]    = en_power_q;
    enable_word[`MTIA_BIT_FIELDBUS] = en_fb_q;
    enable_word[`MTIA_BIT_TIMER]    = en_timer_q;
    enable_word[`MTIA_BIT_SW]       = en_sw_q;
    enable_word[`MTIA_BIT_READY]    = en_ready_q;
  end

  wire int_line = |(status_word & enable_word);

  reg [31:0] cfg_word;
  always @* begin
    cfg_word                                      = `MTIA_RST_WORD;
    cfg_word[`MTIA_CFG_DEAS_HI:`MTIA_CFG_DEAS_LO] = deas_field_q;
    cfg_word[`MTIA_CFG_DEAS_STS]                  = deas_busy_q;
    cfg_word[`MTIA_CFG_MASTER]                    = int_line;
    cfg_word[`MTIA_CFG_PIN_EN]                    = pin_en_q;
    cfg_word[`MTIA_CFG_POL]                       = pol_high_q;
    cfg_word[`MTIA_CFG_TYPE]                      = push_pull_q;
  end

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  assign s_axi_awready = clk_en & ~aw_full_q;
  assign s_axi_wready  = clk_en & ~w_full_q;
  assign s_axi_bvalid  = clk_en & b_valid_q;
  assign s_axi_bresp   = b_resp_q;
  assign s_axi_arready = clk_en & ~r_valid_q;
  assign s_axi_rvalid  = clk_en & r_valid_q;
  assign s_axi_rdata   = r_data_q;
  assign s_axi_rresp   = r_resp_q;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  // write waits for both halves and a free response slot
  wire do_wr   = aw_full_q & w_full_q & ~b_valid_q;

  wire hit_cfg = aw_addr_q == `MTIA_OFS_PIN_CFG;
  wire hit_sts = aw_addr_q == `MTIA_OFS_STATUS;
  wire hit_en  = aw_addr_q == `MTIA_OFS_ENABLE;
  wire wr_cfg  = do_wr & hit_cfg;
  wire wr_sts  = do_wr & hit_sts;
  wire wr_en   = do_wr & hit_en;

  // byte lanes expanded to a bit mask
  wire [31:0] lane_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                           {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wbits     = w_data_q & lane_mask;
  wire [31:0] cfg_new   = (cfg_word & ~lane_mask) | wbits;
  wire [31:0] en_new    = (enable_word & ~lane_mask) | wbits;

  wire deas_lane = lane_mask[`MTIA_CFG_DEAS_LO];
  wire [7:0] deas_new = cfg_new[`MTIA_CFG_DEAS_HI:`MTIA_CFG_DEAS_LO];
  wire deas_zero_wr = wr_cfg & deas_lane & (deas_new == `MTIA_RST_DEAS);
  wire deas_clr_wr  = wr_cfg & wbits[`MTIA_CFG_DEAS_CLR];

  // ----------------------------------------
  // flag events
  // ----------------------------------------
  wire timer_set = timer_wrap_pulse & timer_run_enable;
  wire sw_set    = wr_en & en_new[`MTIA_BIT_SW] & ~en_sw_q;
  wire ready_set = device_ready & ~ready_seen_q;

  // ----------------------------------------
  // pin state and de-assertion timer
  // ----------------------------------------
  wire pin_en_d   = wr_cfg ? cfg_new[`MTIA_CFG_PIN_EN] : pin_en_q;
  wire want_pin   = int_line & pin_en_q;
  wire pin_drop   = pin_active_q & ~want_pin;
  // interval only blocks a new assertion, never an active pin
  wire pin_rise   = ~pin_active_q & want_pin & ~deas_busy_q;
  wire deas_on    = deas_field_q != `MTIA_RST_DEAS;
  wire pre_end    = pre_cnt_q == (UNIT_CYC - PRE_ONE);
  wire units_done = pre_end & ((unit_cnt_q + UNIT_ONE) >= deas_field_q);
  wire pin_act_d  = pin_active_q ? want_pin : pin_rise;
  wire level_d    = pol_high_q ? pin_act_d : ~pin_act_d;

  assign irq_out  = irq_out_q;
  assign irq_oe_n = irq_oe_n_q;

  // ----------------------------------------
  // bus channel state
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= {`MTIA_ADDR_W{1'b0}};
      w_full_q  <= 1'b0;
      w_data_q  <= `MTIA_RST_WORD;
      w_strb_q  <= 4'h0;
      b_valid_q <= 1'b0;
      b_resp_q  <= `MTIA_RESP_OKAY;
      r_valid_q <= 1'b0;
      r_data_q  <= `MTIA_RST_WORD;
      r_resp_q  <= `MTIA_RESP_OKAY;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        b_valid_q <= 1'b1;
        b_resp_q  <= (hit_cfg | hit_sts | hit_en) ? `MTIA_RESP_OKAY
                                                  : `MTIA_RESP_SLVERR;
      end else if (b_valid_q & s_axi_bready) begin
        b_valid_q <= 1'b0;
      end
      if (ar_take) begin
        r_valid_q <= 1'b1;
        r_resp_q  <= `MTIA_RESP_OKAY;
        case (s_axi_araddr)
          `MTIA_OFS_PIN_CFG: r_data_q <= cfg_word;
          `MTIA_OFS_STATUS:  r_data_q <= status_word;
          `MTIA_OFS_ENABLE:  r_data_q <= enable_word;
          default: begin
            r_data_q <= `MTIA_RST_WORD;
            r_resp_q <= `MTIA_RESP_SLVERR;
          end
        endcase
      end else if (r_valid_q & s_axi_rready) begin
        r_valid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // configuration and enable registers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      deas_field_q <= `MTIA_RST_DEAS;
      pin_en_q     <= 1'b0;
      pol_high_q   <= 1'b0;
      push_pull_q  <= 1'b0;
      en_phy_a_q   <= 1'b0;
      en_phy_b_q   <= 1'b0;
      en_power_q   <= 1'b0;
      en_timer_q   <= 1'b0;
      en_fb_q      <= 1'b0;
      en_sw_q      <= 1'b0;
      en_ready_q   <= 1'b0;
    end else if (clk_en) begin
      if (wr_cfg) begin
        deas_field_q <= deas_new;
        pin_en_q     <= pin_en_d;
        pol_high_q   <= cfg_new[`MTIA_CFG_POL];
        push_pull_q  <= cfg_new[`MTIA_CFG_TYPE];
      end
      if (wr_en) begin
        en_phy_a_q <= en_new[`MTIA_BIT_PHY_A];
        en_phy_b_q <= en_new[`MTIA_BIT_PHY_B];
        en_power_q <= en_new[`MTIA_BIT_POWER];
        en_timer_q <= en_new[`MTIA_BIT_TIMER];
        en_fb_q    <= en_new[`MTIA_BIT_FIELDBUS];
        en_sw_q    <= en_new[`MTIA_BIT_SW];
        en_ready_q <= en_new[`MTIA_BIT_READY];
      end
    end
  end

  // ----------------------------------------
  // held status flags, set wins over clear
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      timer_flag_q <= 1'b0;
      sw_flag_q    <= 1'b0;
      ready_flag_q <= 1'b0;
      ready_seen_q <= 1'b0;
    end else if (clk_en) begin
      ready_seen_q <= device_ready;
      timer_flag_q <= timer_set |
                      (timer_flag_q & ~(wr_sts & wbits[`MTIA_BIT_TIMER]));
      sw_flag_q    <= sw_set |
                      (sw_flag_q & ~(wr_sts & wbits[`MTIA_BIT_SW]));
      ready_flag_q <= ready_set |
                      (ready_flag_q & ~(wr_sts & wbits[`MTIA_BIT_READY]));
    end
  end

  // ----------------------------------------
  // pin control and de-assertion interval
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      pin_active_q <= 1'b0;
      deas_busy_q  <= 1'b0;
      pre_cnt_q    <= 16'h0000;
      unit_cnt_q   <= 8'h00;
      irq_out_q    <= 1'b1;
      irq_oe_n_q   <= 1'b1;
    end else if (clk_en) begin
      pin_active_q <= pin_act_d;
      // zero field ends any interval at once, pending line goes out
      if (deas_zero_wr) begin
        deas_busy_q <= 1'b0;
        pre_cnt_q   <= 16'h0000;
        unit_cnt_q  <= 8'h00;
      end else if (deas_clr_wr | pin_drop) begin
        deas_busy_q <= deas_on;
        pre_cnt_q   <= 16'h0000;
        unit_cnt_q  <= 8'h00;
      end else if (deas_busy_q) begin
        if (~deas_on | units_done) begin
          deas_busy_q <= 1'b0;
          pre_cnt_q   <= 16'h0000;
          unit_cnt_q  <= 8'h00;
        end else if (pre_end) begin
          pre_cnt_q  <= 16'h0000;
          unit_cnt_q <= unit_cnt_q + UNIT_ONE;
        end else begin
          pre_cnt_q <= pre_cnt_q + PRE_ONE;
        end
      end
      // open-drain only pulls low, push-pull always drives
      if (push_pull_q) begin
        irq_out_q  <= level_d;
        irq_oe_n_q <= 1'b0;
      end else begin
        irq_out_q  <= 1'b0;
        irq_oe_n_q <= level_d;
      end
    end
  end

endmodule // mtia_top

// [mtia_regs.vh]
`ifndef MTIA_REGS_VH
`define MTIA_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MTIA_ADDR_W          12
`define MTIA_OFS_PIN_CFG     12'h054
`define MTIA_OFS_STATUS      12'h058
`define MTIA_OFS_ENABLE      12'h05C

// ----------------------------------------
// pin configuration fields
// ----------------------------------------
`define MTIA_CFG_DEAS_HI     31
`define MTIA_CFG_DEAS_LO     24
`define MTIA_CFG_DEAS_CLR    14
`define MTIA_CFG_DEAS_STS    13
`define MTIA_CFG_MASTER      12
`define MTIA_CFG_PIN_EN      8
`define MTIA_CFG_POL         4
`define MTIA_CFG_TYPE        0

// ----------------------------------------
// status and enable bit positions
// ----------------------------------------
`define MTIA_BIT_SW          31
`define MTIA_BIT_READY       30
`define MTIA_BIT_PHY_B       27
`define MTIA_BIT_PHY_A       26
`define MTIA_BIT_TIMER       19
`define MTIA_BIT_POWER       17
`define MTIA_BIT_FIELDBUS    0

// ----------------------------------------
// reset values
// ----------------------------------------
`define MTIA_RST_DEAS        8'h00
`define MTIA_RST_WORD        32'h0000_0000

// ----------------------------------------
// timing
// ----------------------------------------
`define MTIA_DEAS_UNIT_NS    10000
`define MTIA_CLK_NS          10

// ----------------------------------------
// bus responses
// ----------------------------------------
`define MTIA_RESP_OKAY       2'h0
`define MTIA_RESP_SLVERR     2'h2

`endif

// [mtia_top_chk.sv]
`include "mtia_regs.vh"
module mtia_chk #(
  parameter PHY_EVENTS   = 9,
  parameter POWER_EVENTS = 5,
  parameter FB_EVENTS    = 32
) (
  input wire                    sys_clk,
  input wire                    reset,
  input wire [`MTIA_ADDR_W-1:0] s_axi_awaddr,
  input wire                    s_axi_awvalid,
  input wire                    s_axi_awready,
  input wire [31:0]             s_axi_wdata,
  input wire [3:0]              s_axi_wstrb,
  input wire                    s_axi_wvalid,
  input wire                    s_axi_wready,
  input wire                    s_axi_bvalid,
  input wire [PHY_EVENTS-1:0]   phy_first_source_flags,
  input wire [PHY_EVENTS-1:0]   phy_first_event_mask,
  input wire [PHY_EVENTS-1:0]   phy_second_source_flags,
  input wire [PHY_EVENTS-1:0]   phy_second_event_mask,
  input wire [POWER_EVENTS-1:0] power_event_flags,
  input wire [POWER_EVENTS-1:0] power_event_enables,
  input wire [FB_EVENTS-1:0]    fieldbus_event_request,
  input wire [FB_EVENTS-1:0]    fieldbus_event_mask,
  input wire                    timer_wrap_pulse,
  input wire                    timer_run_enable,
  input wire                    irq_out,
  input wire                    irq_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // shadow of pin config and enable, snooped from the write channel
  logic [11:0] a_q;
  logic [31:0] d_q, m_q, cfg_q, en_q;
  logic        bv_q, seen_q;
  logic [1:0]  age_q;
  wire         done = s_axi_bvalid && !bv_q;
  wire [31:0]  m = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
                    {8{s_axi_wstrb[0]}}};
  always @(posedge sys_clk) begin
    if (reset) begin
      cfg_q  <= 32'h0000_0000;
      en_q   <= 32'h0000_0000;
      bv_q   <= 1'b0;
      seen_q <= 1'b0;
      age_q  <= 2'd0;
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        d_q <= s_axi_wdata;
        m_q <= m;
      end
      if (done && (a_q == `MTIA_OFS_PIN_CFG || a_q == `MTIA_OFS_ENABLE)) age_q <= 2'd0;
      else if (age_q != 2'd3) age_q <= age_q + 2'd1;
      if (done && a_q == `MTIA_OFS_PIN_CFG) begin
        cfg_q  <= (cfg_q & ~m_q) | (d_q & m_q);
        seen_q <= 1'b1;
      end
      if (done && a_q == `MTIA_OFS_ENABLE) en_q <= (en_q & ~m_q) | (d_q & m_q);
    end
  end
  wire       pol = cfg_q[`MTIA_CFG_POL];
  wire       typ = cfg_q[`MTIA_CFG_TYPE];
  wire       pen = cfg_q[`MTIA_CFG_PIN_EN];
  wire [7:0] fld = cfg_q[`MTIA_CFG_DEAS_HI:`MTIA_CFG_DEAS_LO];
  wire       ok  = seen_q && age_q == 2'd3;
  wire act  = typ ? (!irq_oe_n && irq_out == pol) : (!irq_out && irq_oe_n == pol);
  wire idle = typ ? (!irq_oe_n && irq_out == !pol) : (!irq_out && irq_oe_n == !pol);
  wire line = (|(phy_first_source_flags & phy_first_event_mask) && en_q[`MTIA_BIT_PHY_A])
    || (|(phy_second_source_flags & phy_second_event_mask) && en_q[`MTIA_BIT_PHY_B])
    || (|(power_event_flags & power_event_enables) && en_q[`MTIA_BIT_POWER])
    || (|(fieldbus_event_request & fieldbus_event_mask) && en_q[`MTIA_BIT_FIELDBUS]);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_OFF_IDLE: assert property (ok && !pen |-> idle)
    else $error("pin not idle while output disabled");
  AST_NO_ENABLE: assert property (ok && en_q == 32'h0000_0000 |-> idle)
    else $error("pin active with every enable clear");
  AST_PUSH_PULL: assert property (ok && typ |-> !irq_oe_n)
    else $error("push-pull pin not driven");
  AST_OPEN_DRAIN: assert property (ok && !typ |-> !irq_out)
    else $error("open-drain pin drives high");
  AST_LINE_PIN: assert property (ok && pen && fld == 8'h00 && line && $past(line)
    && $past(line, 2) && $past(line, 3) |-> act) else $error("enabled source without pin");
  AST_HOLD_OFF: assert property (ok && fld != 8'h00 && $past(act) && !act |=> !act [*8])
    else $error("pin reasserted inside interval");
  AST_TIMER: assert property (ok && pen && fld == 8'h00 && en_q[`MTIA_BIT_TIMER]
    && timer_wrap_pulse && timer_run_enable |-> ##[1:4] act) else $error("timer wrap lost");
  AST_SOFT: assert property (seen_q && pen && fld == 8'h00 && $rose(en_q[`MTIA_BIT_SW])
    |-> ##[0:4] act) else $error("software event lost");
endmodule // mtia_chk
bind mtia_top mtia_chk #(.PHY_EVENTS(PHY_EVENTS), .POWER_EVENTS(POWER_EVENTS), .FB_EVENTS(FB_EVENTS))
  u_chk (.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .phy_first_source_flags, .phy_first_event_mask,
  .phy_second_source_flags, .phy_second_event_mask, .power_event_flags, .power_event_enables,
  .fieldbus_event_request, .fieldbus_event_mask, .timer_wrap_pulse, .timer_run_enable, .irq_out,
  .irq_oe_n);

// [mtia_host_model.sv]
module mtia_host_model (
  input  wire irq_out,
  input  wire irq_oe_n,
  output wire pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // shared line with a pull-up: released means high
  assign pin_level = irq_oe_n ? 1'b1 : irq_out;
endmodule // mtia_host_model

// [tb_multi_tier_interrupt_aggregator.sv]
`include "mtia_regs.vh"
module tb_multi_tier_interrupt_aggregator;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         irq_out, irq_oe_n, pin_level;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  logic [8:0]  phy_first_source_flags = 9'h000, phy_second_source_flags = 9'h000;
  logic [8:0]  phy_first_event_mask = 9'h1FE, phy_second_event_mask = 9'h1FE;
  logic [4:0]  power_event_flags = 5'h00, power_event_enables = 5'h1E;
  logic [31:0] fieldbus_event_request = 32'h0000_0000, fieldbus_event_mask = 32'hFFFF_FFFE;
  logic        timer_wrap_pulse = 1'b0, timer_run_enable = 1'b0, device_ready = 1'b0;
  logic        clk_en = 1'b1;
  logic [31:0] rd_q;
  logic [1:0]  resp_q;
  int          fail_count = 0, n_compared = 0;
  int          pos[4] = '{`MTIA_BIT_PHY_A, `MTIA_BIT_PHY_B, `MTIA_BIT_POWER, `MTIA_BIT_FIELDBUS};
  always #5 sys_clk = ~sys_clk;
  mtia_top u_dut (.sys_clk, .reset, .clk_en, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
    .phy_first_source_flags, .phy_first_event_mask, .phy_second_source_flags,
    .phy_second_event_mask, .power_event_flags, .power_event_enables, .fieldbus_event_request,
    .fieldbus_event_mask, .timer_wrap_pulse, .timer_run_enable, .device_ready, .irq_out, .irq_oe_n);
  mtia_host_model u_host (.irq_out, .irq_oe_n, .pin_level);
  task automatic conclude();
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge sys_clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      resp_q = s_axi_bresp;
      @(posedge sys_clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end while (!bh);
    chk({30'h0, resp_q}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a);
    logic ah, rh;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge sys_clk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      @(posedge sys_clk);
      if (ah) s_axi_arvalid <= 1'b0;
    end while (!rh);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_q, e);
  endtask
  task automatic pchk(input logic e);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({31'h0, pin_level}, {31'h0, e});
    @(posedge sys_clk);
  endtask
  task automatic set_src(input int i, input logic [1:0] v);
    case (i)
      0: phy_first_source_flags <= {7'h00, v};
      1: phy_second_source_flags <= {7'h00, v};
      2: power_event_flags <= {3'h0, v};
      default: fieldbus_event_request <= {30'h0, v};
    endcase
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic tmr(input logic r);
    timer_run_enable <= r;
    timer_wrap_pulse <= 1'b1;
    @(posedge sys_clk);
    timer_wrap_pulse <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rchk(`MTIA_OFS_PIN_CFG, 32'h0000_0000);
    rchk(`MTIA_OFS_STATUS, 32'h0000_0000);
    rchk(`MTIA_OFS_ENABLE, 32'h0000_0000);
    rchk(12'h060, 32'h0000_0000);
    chk({30'h0, resp_q}, {30'h0, `MTIA_RESP_SLVERR});
    wr(12'h060, 32'hFFFF_FFFF, `MTIA_RESP_SLVERR);
    wr(`MTIA_OFS_PIN_CFG, 32'h0000_0111, `MTIA_RESP_OKAY);
    wr(`MTIA_OFS_ENABLE, 32'h0C02_0001, `MTIA_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      set_src(i, 2'h1);
      rchk(`MTIA_OFS_STATUS, 32'h0000_0000);
      set_src(i, 2'h2);
      rchk(`MTIA_OFS_STATUS, 32'h0000_0001 << pos[i]);
      rchk(`MTIA_OFS_PIN_CFG, 32'h0000_1111);
      pchk(1'b1);
      set_src(i, 2'h0);
      rchk(`MTIA_OFS_STATUS, 32'h0000_0000);
      pchk(1'b0);
    end
    set_src(0, 2'h2);
    wr(`MTIA_OFS_PIN_CFG, 32'h0000_0011, `MTIA_RESP_OKAY);
    pchk(1'b0);
    rchk(`MTIA_OFS_PIN_CFG, 32'h0000_1011);
    s_axi_wstrb <= 4'h3;
    wr(`MTIA_OFS_PIN_CFG, 32'hFFFF_0100, `MTIA_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    pchk(1'b0);
    rchk(`MTIA_OFS_PIN_CFG, 32'h0000_1100);
    set_src(0, 2'h0);
    pchk(1'b1);
    wr(`MTIA_OFS_PIN_CFG, 32'h0100_0111, `MTIA_RESP_OKAY);
    set_src(0, 2'h2);
    pchk(1'b1);
    set_src(0, 2'h0);
    pchk(1'b0);
    set_src(0, 2'h2);
    rchk(`MTIA_OFS_PIN_CFG, 32'h0100_3111);
    repeat (500) @(posedge sys_clk);
    pchk(1'b0);
    repeat (520) @(posedge sys_clk);
    pchk(1'b1);
    set_src(0, 2'h0);
    pchk(1'b0);
    repeat (600) @(posedge sys_clk);
    wr(`MTIA_OFS_PIN_CFG, 32'h0100_4111, `MTIA_RESP_OKAY);
    set_src(0, 2'h2);
    repeat (600) @(posedge sys_clk);
    pchk(1'b0);
    wr(`MTIA_OFS_PIN_CFG, 32'h0000_0111, `MTIA_RESP_OKAY);
    pchk(1'b1);
    rchk(`MTIA_OFS_PIN_CFG, 32'h0000_1111);
    set_src(0, 2'h0);
    wr(`MTIA_OFS_ENABLE, 32'h0008_0000, `MTIA_RESP_OKAY);
    tmr(1'b0);
    rchk(`MTIA_OFS_STATUS, 32'h0000_0000);
    tmr(1'b1);
    rchk(`MTIA_OFS_STATUS, 32'h0008_0000);
    pchk(1'b1);
    wr(`MTIA_OFS_STATUS, 32'h0000_0000, `MTIA_RESP_OKAY);
    rchk(`MTIA_OFS_STATUS, 32'h0008_0000);
    wr(`MTIA_OFS_STATUS, 32'h0008_0000, `MTIA_RESP_OKAY);
    rchk(`MTIA_OFS_STATUS, 32'h0000_0000);
    wr(`MTIA_OFS_ENABLE, 32'h8000_0000, `MTIA_RESP_OKAY);
    rchk(`MTIA_OFS_STATUS, 32'h8000_0000);
    pchk(1'b1);
    wr(`MTIA_OFS_STATUS, 32'h8000_0000, `MTIA_RESP_OKAY);
    rchk(`MTIA_OFS_STATUS, 32'h0000_0000);
    pchk(1'b0);
    device_ready <= 1'b1;
    wr(`MTIA_OFS_ENABLE, 32'h0000_0000, `MTIA_RESP_OKAY);
    rchk(`MTIA_OFS_STATUS, 32'h4000_0000);
    wr(`MTIA_OFS_STATUS, 32'h4000_0000, `MTIA_RESP_OKAY);
    rchk(`MTIA_OFS_STATUS, 32'h0000_0000);
    clk_en <= 1'b0;
    tmr(1'b1);
    clk_en <= 1'b1;
    rchk(`MTIA_OFS_STATUS, 32'h0000_0000);
    conclude();
  end
endmodule // tb_multi_tier_interrupt_aggregator
